// ===== src/flow_port_regs.svh
// Constants shared by both ends of the flow sensor command port
`ifndef FLOW_PORT_REGS_SVH
`define FLOW_PORT_REGS_SVH

`define DEV_ADDR           7'h40
`define ADDR_WR_BYTE       8'h80
`define ADDR_RD_BYTE       8'h81
`define CMD_FLOW           16'h1000
`define CMD_ID             16'h31AE
`define CMD_RESET          16'h2000
`define FLOW_BYTES         3'h2
`define ID_BYTES           3'h4
`define CRC_INIT           8'h00
`define CRC_POLY           8'h31
`define FLOW_OFFSET        32000
`define FLOW_COEF          140

`define CLK_PERIOD_NS      25
`define MEAS_PERIOD_MS     10
`define MEAS_CYCLES        (`MEAS_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define SCL_MIN_PERIOD_NS  2500
`define QUARTER_CYCLES     ((`SCL_MIN_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))
`define READ_GAP_NS        1000
`define READ_GAP_CYCLES    ((`READ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/flow_port_pkg.sv
// Types shared by both ends of the flow sensor command port
package flow_port_pkg;
	typedef enum logic [2:0] {
		ds_idle, ds_addr, ds_ack, ds_rx, ds_tx, ds_txack
	} dev_state_type;
	typedef enum logic [2:0] {
		hs_idle, hs_start, hs_byte, hs_gap, hs_stop
	} host_state_type;
	typedef enum logic [1:0] {
		op_flow, op_id, op_reset
	} host_op_type;
endpackage

// ===== src/flow_bus_if.sv
// Two-wire bus between the host end and the sensor end
interface flow_bus_if;
	logic scl_host_o;
	logic scl_host_oe_n;
	logic sda_host_o;
	logic sda_host_oe_n;
	logic sda_dev_o;
	logic sda_dev_oe_n;
	logic scl;
	logic sda;

	// Pulled-up open-drain wires: any enabled driver low pulls the wire low
	assign scl = scl_host_oe_n | scl_host_o;
	assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);

	modport host (
		output scl_host_o, scl_host_oe_n, sda_host_o, sda_host_oe_n,
		input  scl, sda
	);
	modport dev (
		output sda_dev_o, sda_dev_oe_n,
		input  scl, sda
	);
endinterface

// ===== src/flow_crc8_step.sv
// One byte step of the checksum, MSB first, no reflection or final xor
`include "flow_port_regs.svh"
module flow_crc8_step (
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] crc_out
);
	// Eight shifts of the xored byte under x^8+x^5+x^4+1
	always_comb begin
		logic [7:0] c;
		c = crc_in ^ data_in; // R11
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0}; // R10
		end
		crc_out = c;
	end
endmodule

// ===== src/flow_sensor_dev.sv
// Sensor end: bus slave, command decode, reply framing and sample timer
//
// Contract
// R1 - Answer bus address 0x40, bytes 0x80/0x81
// R2 - Bus runs no faster than 400 kHz
// R3 - Start/stop only when SDA moves, SCL high
// R4 - New sample every 10 ms into output
// R5 - Command 0x1000 returns flow, high byte first
// R6 - Command 0x31AE returns 32-bit ID, MSB first
// R7 - Command 0x2000 soft resets, returns nothing
// R8 - Write command, re-address, then data and CRC
// R9 - Reset frame is header plus two bytes
// R10 - CRC8, init zero, polynomial 0x131
// R11 - Xor byte in, eight MSB-first shifts
// R12 - Host: flow = (raw - 32000) / 140
// R13 - Host discards first reading after init
`include "flow_port_regs.svh"
module flow_sensor_dev
	import flow_port_pkg::*;
#(
	parameter int unsigned MEAS_CYCLES = `MEAS_CYCLES,
	parameter logic [31:0] DEVICE_ID   = 32'h5A5A_0001 // Arbitrary value
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	flow_bus_if.dev          bus,
	input  wire logic [15:0] meas_value,
	output logic             meas_strobe,
	output logic      [15:0] flow_value,
	output logic             soft_reset
);
	dev_state_type state_reg, state_next;
	logic [3:0]  bit_reg, bit_next;
	logic [7:0]  shift_reg, shift_next;
	logic        rw_reg, rw_next;
	logic [15:0] cmd_reg, cmd_next;
	logic [1:0]  rx_cnt_reg, rx_cnt_next;
	logic [2:0]  tx_idx_reg, tx_idx_next;
	logic [2:0]  nbytes_reg, nbytes_next;
	logic [31:0] payload_reg, payload_next;
	logic [7:0]  crc_reg, crc_next;
	logic        ack_reg, ack_next;
	logic        drive_reg, drive_next;
	logic        srst_cmd_reg, srst_cmd_next;
	logic [31:0] tmr_reg, tmr_next;
	logic [15:0] flow_reg, flow_next;
	logic        strobe_reg, strobe_next;
	logic        scl_s1, scl_s2, scl_s3;
	logic        sda_s1, sda_s2, sda_s3;
	logic        scl_rise, scl_fall, start_det, stop_det;
	logic [31:0] tx_word;
	logic [7:0]  tx_byte, crc_upd;

	// Pins come from another domain; two flops before any use
	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= bus.scl;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	// Edges seen two mclk after the wire; far inside a 400 kHz bit
	assign scl_rise  = scl_s2 & ~scl_s3; // R2
	assign scl_fall  = ~scl_s2 & scl_s3;
	assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2; // R3
	assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2; // R3

	// Reply byte: data bytes, then the checksum, then filler
	always_comb begin
		tx_word = payload_reg << {tx_idx_reg, 3'b000};
		if (tx_idx_reg < nbytes_reg) begin
			tx_byte = tx_word[31:24]; // R5 R6
		end else if (tx_idx_reg == nbytes_reg) begin
			tx_byte = crc_reg; // R8
		end else begin
			tx_byte = 8'hFF;
		end
	end

	flow_crc8_step crc_step (
		.crc_in  (crc_reg),
		.data_in (tx_byte),
		.crc_out (crc_upd)
	);

	// Slave protocol machine
	always_comb begin
		state_next    = state_reg;
		bit_next      = bit_reg;
		shift_next    = shift_reg;
		rw_next       = rw_reg;
		cmd_next      = cmd_reg;
		rx_cnt_next   = rx_cnt_reg;
		tx_idx_next   = tx_idx_reg;
		nbytes_next   = nbytes_reg;
		payload_next  = payload_reg;
		crc_next      = crc_reg;
		ack_next      = ack_reg;
		srst_cmd_next = 1'b0;
		if (stop_det) begin
			state_next = ds_idle;
			// Only a bare two-byte write frame counts as a reset
			if (!rw_reg && rx_cnt_reg == 2'h2 && cmd_reg == `CMD_RESET) begin
				srst_cmd_next = 1'b1; // R7 R9
			end
		end else if (start_det) begin
			state_next = ds_addr; // R3
			bit_next   = 4'h0;
		end else begin
			unique case (state_reg)
				ds_idle: begin
				end
				ds_addr, ds_rx: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s2};
						bit_next   = bit_reg + 4'h1;
					end
					if (scl_fall && bit_reg == 4'h8) begin
						bit_next = 4'h0;
						if (state_reg == ds_rx) begin
							cmd_next   = {cmd_reg[7:0], shift_reg}; // R8
							state_next = ds_ack;
							if (rx_cnt_reg != 2'h3) begin
								rx_cnt_next = rx_cnt_reg + 2'h1;
							end
						end else if (shift_reg[7:1] == `DEV_ADDR) begin
							state_next = ds_ack; // R1
							rw_next    = shift_reg[0];
							if (!shift_reg[0]) begin
								rx_cnt_next = 2'h0;
							end else begin
								// Freeze the reply so a refresh cannot split it
								tx_idx_next = 3'h0;
								crc_next    = `CRC_INIT; // R10
								if (cmd_reg == `CMD_FLOW) begin
									payload_next = {flow_reg, 16'h0000}; // R5
									nbytes_next  = `FLOW_BYTES;
								end else if (cmd_reg == `CMD_ID) begin
									payload_next = DEVICE_ID; // R6
									nbytes_next  = `ID_BYTES;
								end else begin
									payload_next = 32'h0000_0000;
									nbytes_next  = 3'h0;
								end
							end
						end else begin
							state_next = ds_idle;
						end
					end
				end
				ds_ack: begin
					if (scl_fall) begin
						if (rw_reg) begin
							state_next  = ds_tx;
							shift_next  = tx_byte;
							tx_idx_next = tx_idx_reg + 3'h1;
							if (tx_idx_reg < nbytes_reg) begin
								crc_next = crc_upd; // R10
							end
						end else begin
							state_next = ds_rx;
						end
					end
				end
				ds_tx: begin
					if (scl_fall) begin
						shift_next = {shift_reg[6:0], 1'b1};
						bit_next   = bit_reg + 4'h1;
						if (bit_reg == 4'h7) begin
							bit_next   = 4'h0;
							state_next = ds_txack;
						end
					end
				end
				ds_txack: begin
					if (scl_rise) begin
						ack_next = ~sda_s2;
					end
					if (scl_fall) begin
						if (ack_reg) begin
							state_next  = ds_tx;
							shift_next  = tx_byte;
							tx_idx_next = tx_idx_reg + 3'h1;
							if (tx_idx_reg < nbytes_reg) begin
								crc_next = crc_upd;
							end
						end else begin
							state_next = ds_idle;
						end
					end
				end
			endcase
		end
		// Pull SDA low for our ack or for a zero data bit
		drive_next = (state_next == ds_ack) ||
			(state_next == ds_tx && !shift_next[7]);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg    <= ds_idle;
			bit_reg      <= 4'h0;
			shift_reg    <= 8'h00;
			rw_reg       <= 1'b0;
			cmd_reg      <= 16'h0000;
			rx_cnt_reg   <= 2'h0;
			tx_idx_reg   <= 3'h0;
			nbytes_reg   <= 3'h0;
			payload_reg  <= 32'h0000_0000;
			crc_reg      <= `CRC_INIT;
			ack_reg      <= 1'b0;
			drive_reg    <= 1'b0;
			srst_cmd_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			bit_reg      <= bit_next;
			shift_reg    <= shift_next;
			rw_reg       <= rw_next;
			cmd_reg      <= cmd_next;
			rx_cnt_reg   <= rx_cnt_next;
			tx_idx_reg   <= tx_idx_next;
			nbytes_reg   <= nbytes_next;
			payload_reg  <= payload_next;
			crc_reg      <= crc_next;
			ack_reg      <= ack_next;
			drive_reg    <= drive_next;
			srst_cmd_reg <= srst_cmd_next;
		end
	end

	// Sample timer; a soft reset restarts it and drops the held value
	always_comb begin
		tmr_next    = tmr_reg + 32'h1;
		flow_next   = flow_reg;
		strobe_next = 1'b0;
		if (srst_cmd_reg) begin
			tmr_next  = 32'h0; // R7
			flow_next = 16'h0000;
		end else if (tmr_reg == MEAS_CYCLES - 1) begin
			tmr_next    = 32'h0;
			flow_next   = meas_value; // R4
			strobe_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tmr_reg    <= 32'h0;
			flow_reg   <= 16'h0000;
			strobe_reg <= 1'b0;
		end else begin
			tmr_reg    <= tmr_next;
			flow_reg   <= flow_next;
			strobe_reg <= strobe_next;
		end
	end

	assign bus.sda_dev_o    = 1'b0;
	assign bus.sda_dev_oe_n = ~drive_reg;
	assign meas_strobe      = strobe_reg;
	assign flow_value       = flow_reg;
	assign soft_reset       = srst_cmd_reg;
endmodule

// ===== src/flow_sensor_host.sv
// Host end: bus master that runs the three commands and checks replies
`include "flow_port_regs.svh"
module flow_sensor_host
	import flow_port_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	flow_bus_if.host         bus,
	input  wire logic        cmd_valid,
	input  host_op_type      cmd_op,
	output logic             cmd_ready,
	output logic             rsp_valid,
	output logic      [31:0] rsp_data,
	output logic             rsp_crc_ok,
	output logic             rsp_nack,
	output logic             rsp_discard,
	output logic      [15:0] flow_slm
);
	host_state_type state_reg, state_next;
	host_op_type    op_reg, op_next;
	logic [15:0] q_reg, q_next;
	logic [1:0]  ph_reg, ph_next;
	logic [3:0]  bit_reg, bit_next;
	logic [3:0]  idx_reg, idx_next;
	logic [7:0]  tx_reg, tx_next;
	logic [7:0]  rx_reg, rx_next;
	logic [31:0] data_reg, data_next;
	logic [7:0]  crc_reg, crc_next, crc_upd;
	logic        nak_reg, nak_next, nack_reg, nack_next;
	logic        ok_reg, ok_next, first_reg, first_next;
	logic        scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;
	logic        vld_reg, vld_next, disc_reg, disc_next;
	logic [15:0] slm_reg, slm_next;
	logic        sda_s1, sda_s2, tick, writing;
	logic [3:0]  last_idx;
	logic [15:0] cmd_word;
	logic [31:0] slm_full;

	// Byte written at a given position of the write part of a frame
	function automatic logic [7:0] wr_byte(input logic [3:0] idx,
		input logic [15:0] cmd);
		unique case (idx)
			4'h0:    wr_byte = `ADDR_WR_BYTE; // R8
			4'h1:    wr_byte = cmd[15:8];
			4'h2:    wr_byte = cmd[7:0];
			default: wr_byte = `ADDR_RD_BYTE;
		endcase
	endfunction

	// SDA is from the wire; resync before sampling
	always_ff @(posedge mclk) begin
		if (srst) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
		end
	end

	always_comb begin
		unique case (op_reg)
			op_flow: cmd_word = `CMD_FLOW; // R5
			op_id:   cmd_word = `CMD_ID; // R6
			op_reset: cmd_word = `CMD_RESET; // R7
		endcase
	end
	assign last_idx = (op_reg == op_id) ? 4'h8 : 4'h6;
	assign writing  = idx_reg <= 4'h3;
	// Quarter of an SCL period keeps the bus at or under 400 kHz
	assign tick = (state_reg == hs_gap) ?
		(q_reg == 16'(`READ_GAP_CYCLES - 1)) :
		(q_reg == 16'(`QUARTER_CYCLES - 1)); // R2

	flow_crc8_step crc_step (
		.crc_in  (crc_reg),
		.data_in (rx_reg),
		.crc_out (crc_upd)
	);

	// Raw to flow; signed so reverse flow comes out negative
	assign slm_full = ($signed({16'h0000, data_reg[15:0]}) -
		$signed(32'(`FLOW_OFFSET))) / $signed(32'(`FLOW_COEF)); // R12

	// Master sequencer
	always_comb begin
		state_next = state_reg;
		op_next    = op_reg;
		q_next     = (state_reg == hs_idle || tick) ? 16'h0000 : q_reg + 16'h1;
		ph_next    = (tick && state_reg != hs_gap) ? ph_reg + 2'h1 : ph_reg;
		bit_next   = bit_reg;
		idx_next   = idx_reg;
		tx_next    = tx_reg;
		rx_next    = rx_reg;
		data_next  = data_reg;
		crc_next   = crc_reg;
		nak_next   = nak_reg;
		nack_next  = nack_reg;
		ok_next    = ok_reg;
		first_next = first_reg;
		vld_next   = 1'b0;
		disc_next  = disc_reg;
		slm_next   = slm_reg;
		unique case (state_reg)
			hs_idle: begin
				ph_next = 2'h0;
				if (cmd_valid) begin
					state_next = hs_start;
					op_next    = cmd_op;
					idx_next   = 4'h0;
					data_next  = 32'h0000_0000;
					crc_next   = `CRC_INIT; // R10
					nack_next  = 1'b0;
					ok_next    = 1'b1;
				end
			end
			hs_start: begin
				if (tick && ph_reg == 2'h3) begin
					state_next = hs_byte;
					bit_next   = 4'h0;
					tx_next    = wr_byte(idx_reg, cmd_word);
				end
			end
			hs_byte: begin
				if (tick && ph_reg == 2'h1) begin
					if (bit_reg != 4'h8) begin
						rx_next = {rx_reg[6:0], sda_s2};
					end else begin
						nak_next = sda_s2;
					end
				end
				if (tick && ph_reg == 2'h3) begin
					if (bit_reg != 4'h8) begin
						bit_next = bit_reg + 4'h1;
						tx_next  = {tx_reg[6:0], 1'b1};
					end else begin
						bit_next = 4'h0;
						if (writing && nak_reg) begin
							nack_next  = 1'b1;
							ok_next    = 1'b0;
							state_next = hs_stop;
						end else if (idx_reg == 4'h2) begin
							// Reset frame ends after the command word
							state_next = (op_reg == op_reset) ? hs_stop : hs_gap; // R9
						end else if (idx_reg == last_idx) begin
							ok_next    = (rx_reg == crc_reg); // R10
							state_next = hs_stop;
						end else begin
							idx_next = idx_reg + 4'h1;
							tx_next  = wr_byte(idx_reg + 4'h1, cmd_word);
							if (!writing) begin
								data_next = {data_reg[23:0], rx_reg}; // R5 R6
								crc_next  = crc_upd; // R11
							end
						end
					end
				end
			end
			hs_gap: begin
				// Clock held low for the delay, then a repeated start
				if (tick) begin
					state_next = hs_start; // R8
					idx_next   = 4'h3;
				end
			end
			hs_stop: begin
				if (tick && ph_reg == 2'h3) begin
					state_next = hs_idle;
					vld_next   = 1'b1;
					disc_next  = first_reg && op_reg == op_flow; // R13
					slm_next   = slm_full[15:0];
					if (op_reg == op_reset && !nack_reg) begin
						first_next = 1'b1; // R13
					end else if (op_reg == op_flow && ok_reg) begin
						first_next = 1'b0;
					end
				end
			end
		endcase
		// Wire levels for the coming quarter
		scl_low_next = 1'b0;
		sda_low_next = 1'b0;
		unique case (state_next)
			hs_idle: begin
			end
			hs_start: begin
				scl_low_next = (ph_next == 2'h0) || (ph_next == 2'h3);
				sda_low_next = ph_next[1]; // R3
			end
			hs_byte: begin
				scl_low_next = (ph_next == 2'h0) || (ph_next == 2'h3);
				if (bit_next != 4'h8) begin
					sda_low_next = (idx_next <= 4'h3) && !tx_next[7];
				end else begin
					sda_low_next = (idx_next > 4'h3) && (idx_next != last_idx);
				end
			end
			hs_gap: begin
				scl_low_next = 1'b1;
			end
			hs_stop: begin
				scl_low_next = ph_next == 2'h0;
				sda_low_next = !ph_next[1]; // R3
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg   <= hs_idle;
			op_reg      <= op_flow;
			q_reg       <= 16'h0000;
			ph_reg      <= 2'h0;
			bit_reg     <= 4'h0;
			idx_reg     <= 4'h0;
			tx_reg      <= 8'hFF;
			rx_reg      <= 8'h00;
			data_reg    <= 32'h0000_0000;
			crc_reg     <= `CRC_INIT;
			nak_reg     <= 1'b0;
			nack_reg    <= 1'b0;
			ok_reg      <= 1'b0;
			first_reg   <= 1'b1;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			vld_reg     <= 1'b0;
			disc_reg    <= 1'b0;
			slm_reg     <= 16'h0000;
		end else begin
			state_reg   <= state_next;
			op_reg      <= op_next;
			q_reg       <= q_next;
			ph_reg      <= ph_next;
			bit_reg     <= bit_next;
			idx_reg     <= idx_next;
			tx_reg      <= tx_next;
			rx_reg      <= rx_next;
			data_reg    <= data_next;
			crc_reg     <= crc_next;
			nak_reg     <= nak_next;
			nack_reg    <= nack_next;
			ok_reg      <= ok_next;
			first_reg   <= first_next;
			scl_low_reg <= scl_low_next;
			sda_low_reg <= sda_low_next;
			vld_reg     <= vld_next;
			disc_reg    <= disc_next;
			slm_reg     <= slm_next;
		end
	end

	assign bus.scl_host_o    = 1'b0;
	assign bus.scl_host_oe_n = ~scl_low_reg;
	assign bus.sda_host_o    = 1'b0;
	assign bus.sda_host_oe_n = ~sda_low_reg;
	assign cmd_ready   = state_reg == hs_idle;
	assign rsp_valid   = vld_reg;
	assign rsp_data    = data_reg;
	assign rsp_crc_ok  = ok_reg;
	assign rsp_nack    = nack_reg;
	assign rsp_discard = disc_reg;
	assign flow_slm    = slm_reg;
endmodule

// ===== sim/flow_port_monitor.sv
// Timing and drive checks on the two-wire bus between the two ends
module flow_port_monitor (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl_host_o,
	input wire logic scl_host_oe_n,
	input wire logic sda_host_o,
	input wire logic sda_host_oe_n,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe_n,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MIN_HALF  = 24; // 0.6 us of SCL high or low
	localparam int MIN_SETUP = 40; // 1 us of data before SCL rises
	localparam int MIN_COND  = 4;  // 0.1 us of SCL high before start/stop
	logic [7:0] hi_reg;
	logic [7:0] lo_reg;
	logic [7:0] dev_reg;
	logic       dev_d_reg;
	logic       frame_reg;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	function automatic logic [7:0] sat(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	// Run lengths saturate so a long idle never looks like a short phase
	always_ff @(posedge mclk) begin
		dev_d_reg <= sda_dev_oe_n;
		if (srst) begin
			hi_reg <= 8'hFF;
			lo_reg <= 8'hFF;
			dev_reg <= 8'hFF;
			frame_reg <= 1'b0;
		end else begin
			hi_reg <= scl ? sat(hi_reg) : 8'h00;
			lo_reg <= scl ? 8'h00 : sat(lo_reg);
			dev_reg <= (sda_dev_oe_n != dev_d_reg) ? 8'h00 : sat(dev_reg);
			if (scl && hi_reg != 8'h00 && sda != $past(sda))
				frame_reg <= !sda;
		end
	end

	a_scl_high_width: assert property ($fell(scl) |-> hi_reg >= MIN_HALF)
		else $error("SCL high phase too short");
	a_scl_low_width: assert property ($rose(scl) |-> lo_reg >= MIN_HALF)
		else $error("SCL low phase too short");
	a_dev_data_setup: assert property ($rose(scl) |-> dev_reg >= MIN_SETUP)
		else $error("Sensor data changed too close to SCL rise");
	a_dev_moves_low: assert property (sda_dev_oe_n != dev_d_reg |->
		!scl && hi_reg == 8'h00)
		else $error("Sensor moved SDA while SCL high");
	a_start_setup: assert property (scl && $fell(sda) |-> hi_reg >= MIN_COND)
		else $error("Start without SCL high setup");
	a_stop_setup: assert property (scl && $rose(sda) |-> hi_reg >= MIN_COND)
		else $error("Stop without SCL high setup");
	a_idle_no_drive: assert property (!frame_reg |-> sda_dev_oe_n)
		else $error("Sensor drove SDA outside a frame");
	a_drive_low_only: assert property (!scl_host_o && !sda_host_o && !sda_dev_o)
		else $error("Open-drain output drives high");
	a_reset_release: assert property (disable iff (1'b0) srst |=>
		scl_host_oe_n && sda_host_oe_n && sda_dev_oe_n)
		else $error("Bus not released after reset");

	c_start: cover property (scl && $fell(sda));
	c_dev_drive: cover property ($fell(sda_dev_oe_n));
	c_stop: cover property (scl && $rose(sda));
endmodule

// ===== sim/flow_sensor_i2c_command_port_tb_top.sv
// Bench joining host and sensor ends, with a decoder on the bus
`include "flow_port_regs.svh"
module flow_sensor_i2c_command_port_tb_top
	import flow_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MEAS = 8000; // Short refresh keeps the run brief
	localparam logic [31:0] ID_VAL = 32'hC3A51E07; // Arbitrary value
	typedef struct {
		host_op_type op;
		logic [31:0] data;
		logic        disc;
	} note_type;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        cmd_valid = 1'b0;
	host_op_type cmd_op = op_flow;
	logic [15:0] meas_value = 16'h0000;
	logic [15:0] meas_prev = 16'h0000;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [31:0] rsp_data;
	logic        rsp_crc_ok;
	logic        rsp_nack;
	logic        rsp_discard;
	logic [15:0] flow_slm;
	logic        meas_strobe;
	logic [15:0] flow_value;
	logic        soft_reset;
	note_type    notes[$];
	logic [7:0]  wire_q[$];
	logic [7:0]  sh = 8'h00;
	logic        scl_d = 1'b1;
	logic        sda_d = 1'b1;
	logic        first = 1'b1;
	logic        since_ok = 1'b0;
	logic        soft_pend = 1'b0;
	int          bit_n = 0;
	int          since = 0;
	int          n_soft = 0;
	int          exp_soft = 0;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          seed = 32'hBD1B1F83;

	flow_bus_if bus ();
	flow_sensor_host i_flow_sensor_host (.mclk(mclk), .srst(srst), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_crc_ok(rsp_crc_ok),
		.rsp_nack(rsp_nack), .rsp_discard(rsp_discard), .flow_slm(flow_slm));
	flow_sensor_dev #(.MEAS_CYCLES(MEAS), .DEVICE_ID(ID_VAL)) i_flow_sensor_dev (
		.mclk(mclk), .srst(srst), .bus(bus), .meas_value(meas_value),
		.meas_strobe(meas_strobe), .flow_value(flow_value),
		.soft_reset(soft_reset));
	flow_port_monitor i_flow_port_monitor (.mclk(mclk), .srst(srst),
		.scl_host_o(bus.scl_host_o), .scl_host_oe_n(bus.scl_host_oe_n),
		.sda_host_o(bus.sda_host_o), .sda_host_oe_n(bus.sda_host_oe_n),
		.sda_dev_o(bus.sda_dev_o), .sda_dev_oe_n(bus.sda_dev_oe_n),
		.scl(bus.scl), .sda(bus.sda));

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic timeout(input string what);
		n_fail++;
		$display("wrong value %s: expected done, seen timeout", what);
		summarize();
	endtask

	// Checksum kept independent of the design's own step logic
	function automatic logic [7:0] crc_byte(input logic [7:0] crc,
		input logic [7:0] d);
		logic [8:0] c;
		c = {1'b0, crc ^ d};
		for (int i = 0; i < 8; i++)
			c = c[7] ? ({c[7:0], 1'b0} ^ 9'h131) : {c[7:0], 1'b0};
		return c[7:0];
	endfunction

	// Note the expected reply, then hold the request until it is taken
	task automatic issue(input host_op_type op, input logic [31:0] data);
		note_type n;
		int k;
		n.op = op;
		n.data = data;
		n.disc = first;
		k = 0;
		notes.push_back(n);
		if (op == op_flow)
			first = 1'b0;
		if (op == op_reset) begin
			first = 1'b1;
			exp_soft++;
		end
		@(negedge mclk);
		cmd_op = op;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) begin
			@(negedge mclk);
			k++;
			if (k > 20000)
				timeout("command take");
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask

	// Read flow just after a refresh so the frozen sample is known
	task automatic flow_fresh();
		int k;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
			if (k > MEAS + 100)
				timeout("refresh");
		end while (meas_strobe !== 1'b1);
		#1;
		issue(op_flow, {16'h0000, meas_prev});
	endtask

	task automatic wait_done(input string name);
		int k;
		k = 0;
		while (notes.size() != 0) begin
			@(negedge mclk);
			k++;
			if (k > 30000)
				timeout(name);
		end
		$display("test %s done", name);
	endtask

	// Compare one reply, and the bytes seen on the wire, with the note
	task automatic check_rsp();
		note_type n;
		logic [7:0] eb[$];
		logic [7:0] crc;
		logic [15:0] cmd;
		int s;
		n = notes.pop_front();
		cmd = (n.op == op_flow) ? `CMD_FLOW : (n.op == op_id) ? `CMD_ID : `CMD_RESET;
		eb = '{`ADDR_WR_BYTE, cmd[15:8], cmd[7:0]};
		crc = `CRC_INIT;
		check("nack", 32'h0, 32'(rsp_nack));
		if (n.op != op_reset) begin
			eb.push_back(`ADDR_RD_BYTE);
			for (int i = (n.op == op_flow) ? 1 : 3; i >= 0; i--) begin
				eb.push_back(n.data[8*i +: 8]);
				crc = crc_byte(crc, n.data[8*i +: 8]);
			end
			eb.push_back(crc);
			check("crc ok", 32'h1, 32'(rsp_crc_ok));
		end
		if (n.op == op_flow) begin
			s = (int'(n.data[15:0]) - `FLOW_OFFSET) / `FLOW_COEF;
			check("flow raw", n.data, {16'h0000, rsp_data[15:0]});
			check("discard", 32'(n.disc), 32'(rsp_discard));
			check("flow slm", {16'h0000, 16'(s)}, {16'h0000, flow_slm});
		end
		if (n.op == op_id)
			check("device id", n.data, rsp_data);
		check("wire bytes", 32'(eb.size()), 32'(wire_q.size()));
		foreach (eb[i])
			if (i < wire_q.size())
				check("wire byte", 32'(eb[i]), 32'(wire_q[i]));
		wire_q.delete();
	endtask

	// Bus decoder: start clears the bit count, eight bits make a byte
	// Sampled mid-cycle so the wires have settled after the launch edge
	always @(negedge mclk) begin
		if (bus.scl && scl_d && sda_d && !bus.sda)
			bit_n = 0;
		else if (bus.scl && !scl_d) begin
			if (bit_n == 8)
				bit_n = 0;
			else begin
				sh = {sh[6:0], bus.sda};
				bit_n = bit_n + 1;
				if (bit_n == 8)
					wire_q.push_back(sh);
			end
		end
		scl_d = bus.scl;
		sda_d = bus.sda;
	end

	// Replies, refresh period and soft reset effect on the sensor side
	always @(negedge mclk) begin
		if (rsp_valid === 1'b1) begin
			if (notes.size() == 0)
				check("reply count", 32'h0, 32'h1);
			else
				check_rsp();
		end
		since = since + 1;
		if (meas_strobe === 1'b1) begin
			if (since_ok)
				check("refresh period", MEAS, since);
			check("refreshed value", 32'(meas_value), 32'(flow_value));
			since = 0;
			since_ok = 1'b1;
		end
		if (soft_pend)
			check("flow after reset", 32'h0, 32'(flow_value));
		soft_pend = (soft_reset === 1'b1);
		if (soft_pend) begin
			n_soft++;
			since_ok = 1'b0;
		end
	end

	// A fresh random sample after each refresh
	always @(negedge mclk) begin
		if (meas_strobe === 1'b1) begin
			meas_prev <= meas_value;
			meas_value <= 16'($random(seed));
		end
	end

	initial begin
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		issue(op_flow, 32'h0);
		wait_done("power up flow");
		repeat (2) flow_fresh();
		wait_done("fresh flow");
		issue(op_id, ID_VAL);
		issue(op_id, ID_VAL);
		wait_done("id back to back");
		issue(op_reset, 32'h0);
		wait_done("soft reset");
		issue(op_flow, 32'h0);
		flow_fresh();
		wait_done("flow after reset");
		repeat (3) begin
			case ($unsigned($random(seed)) % 3)
				0: flow_fresh();
				1: issue(op_id, ID_VAL);
				default: issue(op_reset, 32'h0);
			endcase
			wait_done("random op");
		end
		check("soft resets", exp_soft, n_soft);
		summarize();
	end
endmodule
